// ---- pkg/crpc_pkg.sv ----
// Purpose: Shared constants and types for the crash recovery power cycler
// Assumes: 20 MHz reference clock
// Notes: Timer counts derive from times in their own units
package crpc_pkg;
    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TMR_W = 20;
    localparam int unsigned RST_PULSE_MS = 31;
    localparam int unsigned BOOT_DLY_MS = 10;
    localparam int unsigned INIT_US = 130;
    // Least times round up to whole cycles
    localparam int unsigned RST_PULSE_CYC = (RST_PULSE_MS * (CLK_HZ / 1000));
    localparam int unsigned BOOT_DLY_CYC = (BOOT_DLY_MS * (CLK_HZ / 1000));
    localparam int unsigned INIT_CYC = (INIT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
    localparam logic [TMR_W-1:0] TMR_ONE = 20'h00001;

    // ************************************************************
    // Sequencer states, Gray coded along the usual path
    // ************************************************************
    typedef enum logic [2:0]
    {
        CRPC_RUN = 3'h0,
        CRPC_PULSE = 3'h1,
        CRPC_INIT = 3'h3,
        CRPC_BDLY = 3'h2
    } crpc_state_t;
endpackage : crpc_pkg

// ---- hw/crpc_timer.sv ----
// Purpose: Load-and-count-down timer with a single expiry pulse
// Assumes: Load value is at least one
// Notes: Expiry fires once per load; a new load rearms it
`timescale 1ns/1ns
module crpc_timer
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic start_i,
    input wire logic [crpc_pkg::TMR_W-1:0] load_i,
    // Status
    output logic busy_o,
    output logic expire_o
);
    logic [crpc_pkg::TMR_W-1:0] cnt_q;
    logic run_q;
    logic exp_q;

    // Countdown; start restarts from the load value
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            cnt_q <= crpc_pkg::TMR_ZERO;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end
        else if (start_i)
        begin
            cnt_q <= load_i;
            run_q <= 1'b1;
            exp_q <= 1'b0;
        end
        else if (run_q && (cnt_q == crpc_pkg::TMR_ONE))
        begin
            cnt_q <= crpc_pkg::TMR_ZERO;
            run_q <= 1'b0;
            exp_q <= 1'b1; // One pulse per load
        end
        else
        begin
            cnt_q <= run_q ? (cnt_q - crpc_pkg::TMR_ONE) : cnt_q;
            exp_q <= 1'b0;
        end
    end

    assign busy_o = run_q;
    assign expire_o = exp_q;
endmodule : crpc_timer

// ---- hw/crpc_top.sv ----
// Purpose: Crash recovery sequencer driving the system reset pin
// Assumes: External gating forms supply enable from reset pin and supply request
// Notes: Timer loads are inputs; software writes them at application init
//
// Functional notes
// - Software programs 31 ms and 10 ms timers
// - Watchdog expiry or button pulse starts recovery
// - Drive reset low and start pulse timer
// - Hold reset low until pulse timer expires
// - After release, 130 us oscillator and option init
// - Run mode entry starts boot-access delay timer
// - No boot memory access before delay expires
`timescale 1ns/1ns
module crpc_top
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Crash sources
    input wire logic watchdog_one_reset_out_i,
    input wire logic watchdog_two_reset_out_i,
    // System reset pin, open drain
    input wire logic system_reset_pin_n_i,
    output logic system_reset_pin_n_o,
    output logic system_reset_pin_n_oe_n_o,
    // Timer settings from software
    input wire logic [crpc_pkg::TMR_W-1:0] reset_pulse_timer_i,
    input wire logic [crpc_pkg::TMR_W-1:0] boot_access_delay_timer_i,
    // Status
    output logic internal_fast_oscillator_en_o,
    output logic run_mode_o,
    output logic boot_access_ok_o
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic pin_prev_q;
    // Pins are asynchronous to ref_clk_i
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            sync1_q <= 3'h1;
            sync2_q <= 3'h1;
        end
        else
        begin
            sync1_q <= {watchdog_two_reset_out_i, watchdog_one_reset_out_i,
                        system_reset_pin_n_i};
            sync2_q <= sync1_q;
        end
    end

    // Edge history of the synchronised pin
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            pin_prev_q <= 1'b1;
        else
            pin_prev_q <= sync2_q[0];
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    crpc_pkg::crpc_state_t state_q;
    logic [crpc_pkg::TMR_W-1:0] init_cnt_q;
    logic crash;
    logic pulse_start;
    logic pulse_exp;
    logic bdly_start;
    logic bdly_exp;

    // Watchdog or button low edge while running
    assign crash = (state_q == crpc_pkg::CRPC_RUN) &&
                   (sync2_q[1] || sync2_q[2] || (pin_prev_q && !sync2_q[0]));
    assign pulse_start = crash; // Same cycle as pin drive

    // State walk: pulse, init, boot delay, run
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            state_q <= crpc_pkg::CRPC_RUN;
        else
        begin
            unique case (state_q)
                crpc_pkg::CRPC_RUN:
                    if (crash)
                        state_q <= crpc_pkg::CRPC_PULSE;
                crpc_pkg::CRPC_PULSE:
                    if (pulse_exp)
                        state_q <= crpc_pkg::CRPC_INIT; // Release pin
                crpc_pkg::CRPC_INIT:
                    if (init_cnt_q == crpc_pkg::TMR_ONE)
                        state_q <= crpc_pkg::CRPC_BDLY;
                crpc_pkg::CRPC_BDLY:
                    if (bdly_exp)
                        state_q <= crpc_pkg::CRPC_RUN;
            endcase
        end
    end

    // Fixed init time counter
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            init_cnt_q <= crpc_pkg::TMR_ZERO;
        else if (pulse_exp)
            init_cnt_q <= crpc_pkg::TMR_W'(crpc_pkg::INIT_CYC);
        else if (init_cnt_q != crpc_pkg::TMR_ZERO)
            init_cnt_q <= init_cnt_q - crpc_pkg::TMR_ONE;
    end

    // Run mode entry starts the boot delay
    assign bdly_start = (state_q == crpc_pkg::CRPC_INIT) &&
                        (init_cnt_q == crpc_pkg::TMR_ONE);

    // ************************************************************
    // Timers
    // ************************************************************
    // Loads come from software settings
    crpc_timer u_pulse_tmr
    (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .start_i(pulse_start),
        .load_i(reset_pulse_timer_i),
        .busy_o(),
        .expire_o(pulse_exp)
    );

    crpc_timer u_bdly_tmr
    (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .start_i(bdly_start),
        .load_i(boot_access_delay_timer_i),
        .busy_o(),
        .expire_o(bdly_exp)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    logic pin_low_q;
    logic osc_q;
    logic boot_ok_q;
    logic run_q;

    // Output flops; pin low starts together with the pulse timer
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            pin_low_q <= 1'b0;
            osc_q <= 1'b1;
            boot_ok_q <= 1'b1;
            run_q <= 1'b1;
        end
        else
        begin
            if (crash)
                pin_low_q <= 1'b1;
            else if (pulse_exp)
                pin_low_q <= 1'b0;
            if (pulse_exp)
                osc_q <= 1'b1; // Oscillator on for init
            else if (crash)
                osc_q <= 1'b0;
            if (crash)
                run_q <= 1'b0;
            else if (bdly_start)
                run_q <= 1'b1;
            // Boot memory gated until delay ends
            if (crash)
                boot_ok_q <= 1'b0;
            else if (bdly_exp)
                boot_ok_q <= 1'b1;
        end
    end

    // Open drain: only ever drives low; the gating follows the pin
    assign system_reset_pin_n_o = 1'b0;
    assign system_reset_pin_n_oe_n_o = !pin_low_q;
    assign internal_fast_oscillator_en_o = osc_q;
    assign run_mode_o = run_q;
    assign boot_access_ok_o = boot_ok_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_crash;
        crash;
    endsequence

    chk_pin_at_crash: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        s_crash |=> !system_reset_pin_n_oe_n_o && !boot_access_ok_o)
        else $error("reset pin not driven at crash");

    chk_pin_release: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        pulse_exp |=> system_reset_pin_n_oe_n_o && (state_q == crpc_pkg::CRPC_INIT))
        else $error("reset pin not released at expiry");

    chk_pin_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (state_q == crpc_pkg::CRPC_PULSE) && !pulse_exp |=> !system_reset_pin_n_oe_n_o)
        else $error("reset pin released early");

    chk_boot_gate: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (state_q != crpc_pkg::CRPC_RUN) |-> !boot_access_ok_o)
        else $error("boot access before delay expiry");

    chk_bdly_start: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        $rose(run_mode_o) |-> $past(bdly_start) && (state_q == crpc_pkg::CRPC_BDLY))
        else $error("boot delay not started at run entry");

    chk_init_len: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        pulse_exp |=> (state_q == crpc_pkg::CRPC_INIT)[*8] ##0 internal_fast_oscillator_en_o)
        else $error("init phase too short");

    chk_boot_ok: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        bdly_exp |=> boot_access_ok_o && (state_q == crpc_pkg::CRPC_RUN))
        else $error("boot access not granted at expiry");

    chk_wdog_trig: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (state_q == crpc_pkg::CRPC_RUN) && sync2_q[1] |=> (state_q == crpc_pkg::CRPC_PULSE))
        else $error("watchdog did not start recovery");

    chk_button_trig: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (state_q == crpc_pkg::CRPC_RUN) && pin_prev_q && !sync2_q[0]
        |=> (state_q == crpc_pkg::CRPC_PULSE) && !system_reset_pin_n_oe_n_o)
        else $error("button pulse did not start recovery");
endmodule : crpc_top

// ---- bench/crpc_supply_model.sv ----
// Purpose: Discrete gating and switched regulators around the reset pin
// Assumes: Pin has a pull-up; a button can short it to ground
// Notes: Rail delay is behavioural, far shorter than real ramps
`timescale 1ns/1ns
module crpc_supply_model
#(
    parameter int RAIL_NS = 100
)
(
    // Device side of the open-drain pin
    input wire logic pin_data_i,
    input wire logic pin_oe_n_i,
    // Board inputs
    input wire logic button_press_i,
    input wire logic core_supply_request_i,
    // Resolved board signals
    output logic system_reset_pin_n_o,
    output logic core_reset_line_n_o,
    output logic peripheral_supply_enable_o,
    output logic peripheral_rail_up_o
);
    // ************************************************************
    // Wire resolution and gating
    // ************************************************************
    // Pull-up wins only when nobody pulls down, so a release reads high
    assign system_reset_pin_n_o = (pin_oe_n_i ? 1'b1 : pin_data_i) & ~button_press_i;
    // Core reset tracks the pin both ways
    assign core_reset_line_n_o = system_reset_pin_n_o;
    // Enable needs both the request and a released pin
    assign peripheral_supply_enable_o =
        system_reset_pin_n_o & core_supply_request_i;
    // Regulators follow their enable after a ramp time; one process owns the rail
    always @(peripheral_supply_enable_o)
        peripheral_rail_up_o <= #RAIL_NS peripheral_supply_enable_o;
endmodule : crpc_supply_model

// ---- bench/crpc_bench.sv ----
// Purpose: Self-checking bench for the crash recovery sequencer
// Assumes: Small timer loads keep each recovery near 2700 cycles
// Notes: Each recovery scenario measures pulse, init and boot delay lengths
`timescale 1ns/1ns
module crpc_bench;
    logic ref_clk_i, srst_i, wd_one, wd_two, button, supply_req;
    logic [crpc_pkg::TMR_W-1:0] pulse_load, boot_load;
    logic pin_n, pin_data, pin_oe_n, osc_en, run_mode, boot_ok;
    logic core_rst_n, supply_en, rail_up;
    int errors, n_compared;

    crpc_top u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .watchdog_one_reset_out_i(wd_one), .watchdog_two_reset_out_i(wd_two),
        .system_reset_pin_n_i(pin_n), .system_reset_pin_n_o(pin_data),
        .system_reset_pin_n_oe_n_o(pin_oe_n), .reset_pulse_timer_i(pulse_load),
        .boot_access_delay_timer_i(boot_load), .internal_fast_oscillator_en_o(osc_en),
        .run_mode_o(run_mode), .boot_access_ok_o(boot_ok));
    crpc_supply_model u_supply (.pin_data_i(pin_data), .pin_oe_n_i(pin_oe_n),
        .button_press_i(button), .core_supply_request_i(supply_req),
        .system_reset_pin_n_o(pin_n), .core_reset_line_n_o(core_rst_n),
        .peripheral_supply_enable_o(supply_en), .peripheral_rail_up_o(rail_up));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_cnt(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp)
        begin
            errors++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt
    task automatic finish_test();
        if (errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // One full recovery; poke fires a second trigger mid-init, which must be ignored
    task automatic run_seq(input int src, input int p, input int b, input bit poke);
        int n;
        // Launch on an edge so every input step is edge aligned
        @(posedge ref_clk_i);
        pulse_load <= crpc_pkg::TMR_W'(p);
        boot_load <= crpc_pkg::TMR_W'(b);
        wd_one <= (src == 0);
        wd_two <= (src == 1);
        button <= (src == 2);
        n = 0;
        while (pin_oe_n !== 1'b0 && n < 10)
        begin
            n++;
            @(posedge ref_clk_i);
            #1;
        end
        check_bit("pin pulled", 1'b0, pin_oe_n);
        check_bit("pin data", 1'b0, pin_data);
        check_bit("osc off", 1'b0, osc_en);
        check_bit("run low", 1'b0, run_mode);
        check_bit("boot blocked", 1'b0, boot_ok);
        check_bit("supply enable", 1'b0, supply_en);
        check_bit("core reset low", 1'b0, core_rst_n);
        n = 0;
        while (pin_oe_n === 1'b0 && n < p + 10)
        begin
            n++;
            @(posedge ref_clk_i);
            wd_one <= 1'b0;
            wd_two <= 1'b0;
            button <= 1'b0;
            #1;
        end
        check_cnt("pulse cycles", p + 1, n);
        check_bit("osc on", 1'b1, osc_en);
        check_bit("core reset up", 1'b1, core_rst_n);
        check_bit("supply enable up", 1'b1, supply_en);
        check_bit("rail down", 1'b0, rail_up);
        n = 0;
        while (run_mode !== 1'b1 && n < 3000)
        begin
            n++;
            @(posedge ref_clk_i);
            wd_two <= poke && n >= 100 && n < 104;
            #1;
            if (n < crpc_pkg::INIT_CYC)
                check_bit("boot early", 1'b0, boot_ok);
        end
        check_cnt("init cycles", int'(crpc_pkg::INIT_CYC), n);
        n = 0;
        while (boot_ok !== 1'b1 && n < b + 10)
        begin
            n++;
            @(posedge ref_clk_i);
            #1;
        end
        check_cnt("boot delay", b + 1, n);
        check_bit("rail up", 1'b1, rail_up);
        repeat (20) @(posedge ref_clk_i);
        #1;
        check_bit("single expiry", 1'b1, pin_oe_n);
    endtask : run_seq

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic scen_reset_state();
        check_bit("reset oe", 1'b1, pin_oe_n);
        check_bit("reset osc", 1'b1, osc_en);
        check_bit("reset run", 1'b1, run_mode);
        check_bit("reset boot", 1'b1, boot_ok);
    endtask : scen_reset_state
    task automatic scen_watchdog_one();
        run_seq(0, 20, 20, 1'b1);
    endtask : scen_watchdog_one
    task automatic scen_watchdog_two_min();
        run_seq(1, 1, 1, 1'b0);
    endtask : scen_watchdog_two_min
    task automatic scen_button();
        run_seq(2, 33, 7, 1'b0);
    endtask : scen_button

    // Clock, 50 ns period
    initial
    begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // Watchdog sized for three recoveries with margin
    initial
    begin
        repeat (30000) @(posedge ref_clk_i);
        errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        errors = 0;
        n_compared = 0;
        srst_i = 1'b1;
        wd_one = 1'b0;
        wd_two = 1'b0;
        button = 1'b0;
        supply_req = 1'b1;
        pulse_load = 20'h00014;
        boot_load = 20'h00014;
        repeat (10) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        #1;
        scen_reset_state();
        // Two edges after release must still show the idle outputs
        repeat (2) @(posedge ref_clk_i);
        #1;
        scen_reset_state();
        @(posedge ref_clk_i);
        scen_watchdog_one();
        scen_watchdog_two_min();
        scen_button();
        finish_test();
    end
endmodule : crpc_bench
